// ---- pkg/tdm_regs.vh ----
`ifndef TDM_REGS_VH
`define TDM_REGS_VH

// serial word width and bit counter width
`define TDM_WORD_W      32
`define TDM_CNT_W       5
// last bit index of a word, counted from zero
`define TDM_WORD_LAST   5'h1F
`define TDM_CNT_ZERO    5'h00
`define TDM_CNT_ONE     5'h01
// depth of each cpu-side fifo and its pointer width
`define TDM_FIFO_DEPTH  32
`define TDM_FIFO_AW     5
// value loaded into the transmitter when the transmit fifo runs dry
`define TDM_TX_IDLE     32'h00000000
`define TDM_RX_RESET    32'h00000000
// number of pins brought through the synchroniser
`define TDM_SYNC_W      3

`endif

// ---- core/tdm_sync2.v ----
`timescale 1ns/1ps
`include "tdm_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// two-stage synchroniser, one chain per bit
module tdm_sync2 #(
    parameter WIDTH = `TDM_SYNC_W
) (
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    genvar g;

    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_bit
            reg meta_q;
            reg sync_q;
            // the first stage feeds only the second stage
            always @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end
                else
                begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q;
        end
    endgenerate

endmodule // tdm_sync2

// ---- core/tdm_fifo.v ----
`timescale 1ns/1ps
`include "tdm_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// flip-flop fifo with valid/ready on both sides
module tdm_fifo #(
    parameter WIDTH = `TDM_WORD_W,
    parameter DEPTH = `TDM_FIFO_DEPTH,
    parameter AW    = `TDM_FIFO_AW
) (
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_wr_data,
    input  wire             i_wr_valid,
    output wire             o_wr_ready,
    output wire [WIDTH-1:0] o_rd_data,
    output wire             o_rd_valid,
    input  wire             i_rd_ready
);

    reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_q;
    reg  [AW-1:0]    rd_ptr_q;
    reg  [AW:0]      count_q;
    wire             push;
    wire             pop;

    // honest full and empty from the word count
    assign o_wr_ready = (count_q != DEPTH[AW:0]);
    assign o_rd_valid = (count_q != {(AW+1){1'b0}});
    assign push       = i_wr_valid & o_wr_ready;
    assign pop        = i_rd_ready & o_rd_valid;
    assign o_rd_data  = mem_q[rd_ptr_q];

    // pointers and fill level
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            if (push & ~pop)
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            else if (pop & ~push)
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
        end
    end

    genvar g;

    // storage, one entry per generate step
    generate
        for (g = 0; g < DEPTH; g = g + 1)
        begin : g_entry
            localparam [AW-1:0] IDX = g;
            always @(posedge i_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    mem_q[g] <= {WIDTH{1'b0}};
                else if (push && (wr_ptr_q == IDX))
                    mem_q[g] <= i_wr_data;
            end
        end
    endgenerate

endmodule // tdm_fifo

// ---- core/tdm_serial_port.v ----
// How it works
// R1 - receive shifter takes one data bit on every bit-clock falling edge
// R2 - transmit shifter moves out one bit on every bit-clock rising edge
// R3 - bit counter counts falls, clears on qualified sync or after 32 bits
// R4 - frame sync is only accepted together with a bit-clock falling edge
// R5 - a word boundary or qualified sync seen with the controller idle starts the next transmit fetch
// R6 - two-bit word counter raises an event every four words, sync clears it
// R7 - word counter steps 00,01,10,11 on match, sync forces 00, holds idle
// R8 - word event is high only in state 11 with match or sync active
// R9 - frame-sync output is made internally and aligned to a rising edge
// R10 - sync fsm: 00 to 01 on sync, 01 to 10 on rise, 10 holds idle
// R11 - frame-sync output high in state 10 unless sync and rise coincide
// R12 - data stage holds serializer bit, updates on rise, drives output
// R13 - frame-sync and data outputs both update on the bit-clock rising edge
// R14 - controller moves words between fifos and shifters, flags every four words
// R15 - on a word boundary, push received word first, then load transmitter
// R16 - transmitter reloads only after its shift for the current edge
// R17 - integrator keeps bit-clock period long against the internal clock
// R18 - far end sends eight 32-bit channels per frame
// R19 - far end drives a one-bit-wide active-high frame sync without delay
// R20 - bit clock passes straight to its output, unregistered
// R21 - bit counter pulses word match at terminal count to the word counter
`timescale 1ns/1ps
`include "tdm_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// tdm-8 serial port: receive and transmit of 32-bit slots on an external clock
module tdm_serial_port (
    input  wire                   I_CLK,
    input  wire                   I_RST_N,
    input  wire                   I_BCLK,
    input  wire                   I_FSYNC,
    input  wire                   I_DATA,
    output wire                   O_BCLK,
    output wire                   O_FSYNC,
    output wire                   O_DATA,
    output wire [`TDM_WORD_W-1:0] O_RX_DATA,
    output wire                   O_RX_VALID,
    input  wire                   I_RX_READY,
    input  wire [`TDM_WORD_W-1:0] I_TX_DATA,
    input  wire                   I_TX_VALID,
    output wire                   O_TX_READY,
    output wire                   O_WORD_GROUP_EVENT
);

    // word counter states
    localparam [3:0] WC_S00 = 4'h1;
    localparam [3:0] WC_S01 = 4'h2;
    localparam [3:0] WC_S10 = 4'h4;
    localparam [3:0] WC_S11 = 4'h8;
    // frame-sync output states
    localparam [2:0] FS_S00 = 3'h1;
    localparam [2:0] FS_S01 = 3'h2;
    localparam [2:0] FS_S10 = 3'h4;
    // data-move controller states
    localparam [3:0] DM_IDLE = 4'h1;
    localparam [3:0] DM_PUSH = 4'h2;
    localparam [3:0] DM_WAIT = 4'h4;
    localparam [3:0] DM_LOAD = 4'h8;

    wire [`TDM_SYNC_W-1:0] pins_sync;
    wire                   bclk_s;
    wire                   fsync_s;
    wire                   data_s;
    reg                    bclk_prev_q;
    wire                   bclk_fall;
    wire                   bclk_rise;
    wire                   fsync_qual;
    wire                   fsync_lowclk;

    reg  [`TDM_WORD_W-1:0] rx_shift_value_q;
    reg  [`TDM_WORD_W-1:0] rx_shift_value_d;
    reg  [`TDM_WORD_W-1:0] rx_word_q;
    reg  [`TDM_WORD_W-1:0] tx_shift_value_q;
    reg  [`TDM_CNT_W-1:0]  bit_cnt_q;
    reg                    word_match_pulse_q;
    reg                    boundary_q;
    wire                   word_boundary;

    reg  [3:0]             wc_q;
    reg  [3:0]             wc_d;
    reg                    wc_event;
    reg  [2:0]             fs_q;
    reg  [2:0]             fs_d;
    reg                    fs_out;
    reg                    frame_sync_out_q;
    reg                    data_latch_q;
    wire                   data_latch_d;

    reg  [3:0]             dm_q;
    reg  [3:0]             dm_d;
    reg                    group_pend_q;
    reg                    word_group_event_q;
    wire                   rx_push_valid;
    wire                   rx_push_ready;
    wire [`TDM_WORD_W-1:0] tx_pop_data;
    wire                   tx_pop_valid;
    wire                   tx_pop_ready;

    ////////////////////////////////////////////////////////////////////////////
    // pins from the far end cross into I_CLK through two flops
    tdm_sync2 #(
        .WIDTH (`TDM_SYNC_W)
    ) u_pin_sync (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_async ({I_DATA, I_FSYNC, I_BCLK}),
        .o_sync  (pins_sync)
    );

    assign bclk_s  = pins_sync[0];
    assign fsync_s = pins_sync[1];
    assign data_s  = pins_sync[2];

    // bit clock goes out untouched to avoid jitter
    assign O_BCLK = I_BCLK;  // see R20

    // edge finder on the synchronised bit clock
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            bclk_prev_q <= 1'b0;
        else
            bclk_prev_q <= bclk_s;
    end

    assign bclk_fall    = bclk_prev_q & ~bclk_s;
    assign bclk_rise    = ~bclk_prev_q & bclk_s;
    assign fsync_qual   = fsync_s & bclk_fall;  // see R4
    assign fsync_lowclk = fsync_s & bclk_fall;  // one-cycle event, so state 01 is not knocked back to 00

    ////////////////////////////////////////////////////////////////////////////
    // receive shifter, msb first
    always @*
    begin
        rx_shift_value_d = rx_shift_value_q;
        if (bclk_fall)
            rx_shift_value_d = {rx_shift_value_q[`TDM_WORD_W-2:0], data_s};  // see R1
    end

    // bit counter, word match pulse and boundary strobe
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rx_shift_value_q   <= `TDM_RX_RESET;
            rx_word_q          <= `TDM_RX_RESET;
            bit_cnt_q          <= `TDM_CNT_ZERO;
            word_match_pulse_q <= 1'b0;
            boundary_q         <= 1'b0;
        end
        else
        begin
            rx_shift_value_q   <= rx_shift_value_d;
            word_match_pulse_q <= 1'b0;
            boundary_q         <= 1'b0;
            if (bclk_fall)
            begin
                if (fsync_qual || (bit_cnt_q == `TDM_WORD_LAST))
                begin
                    bit_cnt_q  <= `TDM_CNT_ZERO;  // see R3
                    boundary_q <= 1'b1;  // see R5
                    rx_word_q  <= rx_shift_value_q;  // this fall's bit opens the next word
                end
                else
                    bit_cnt_q <= bit_cnt_q + `TDM_CNT_ONE;  // see R3
                if (bit_cnt_q == `TDM_WORD_LAST)
                    word_match_pulse_q <= 1'b1;  // see R21
            end
        end
    end

    assign word_boundary = boundary_q;

    ////////////////////////////////////////////////////////////////////////////
    // word counter; sync is the qualified one, delayed to line up with match
    reg fsync_qual_q;

    always @*
    begin
        wc_d     = WC_S00;
        wc_event = 1'b0;
        case (wc_q)
            WC_S00:
                wc_d = fsync_qual_q ? WC_S00 : (word_match_pulse_q ? WC_S01 : WC_S00);  // see R7
            WC_S01:
                wc_d = fsync_qual_q ? WC_S00 : (word_match_pulse_q ? WC_S10 : WC_S01);  // see R7
            WC_S10:
                wc_d = fsync_qual_q ? WC_S00 : (word_match_pulse_q ? WC_S11 : WC_S10);  // see R7
            WC_S11:
            begin
                wc_d     = (fsync_qual_q | word_match_pulse_q) ? WC_S00 : WC_S11;  // see R6
                wc_event = fsync_qual_q | word_match_pulse_q;  // see R8
            end
            default:
                wc_d = WC_S00;
        endcase
    end

    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            wc_q         <= WC_S00;
            fsync_qual_q <= 1'b0;
        end
        else
        begin
            wc_q         <= wc_d;
            fsync_qual_q <= fsync_qual;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame-sync output fsm: e1 is sync seen as the clock goes low, e0 is a rising edge
    always @*
    begin
        fs_d   = FS_S00;
        fs_out = 1'b0;
        case (fs_q)
            FS_S00:
                fs_d = (fsync_lowclk & ~bclk_rise) ? FS_S01 : FS_S00;  // see R10
            FS_S01:
            begin
                if (fsync_lowclk)
                    fs_d = FS_S00;
                else
                    fs_d = bclk_rise ? FS_S10 : FS_S01;  // see R10
            end
            FS_S10:
            begin
                fs_d   = (~fsync_lowclk & ~bclk_rise) ? FS_S10 : FS_S00;  // see R10
                fs_out = ~(fsync_lowclk & bclk_rise);  // see R11
            end
            default:
                fs_d = FS_S00;
        endcase
    end

    // data stage next value: capture serializer msb on a rise, else hold
    assign data_latch_d = bclk_rise ? tx_shift_value_q[`TDM_WORD_W-1] : data_latch_q;  // see R12

    // both output flops load every cycle, but the sync output changes one cycle after the data output
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            fs_q             <= FS_S00;
            frame_sync_out_q <= 1'b0;
            data_latch_q     <= 1'b0;
        end
        else
        begin
            fs_q             <= fs_d;
            frame_sync_out_q <= fs_out;  // see R9
            data_latch_q     <= data_latch_d;  // see R13
        end
    end

    assign O_FSYNC = frame_sync_out_q;
    assign O_DATA  = data_latch_q;

    ////////////////////////////////////////////////////////////////////////////
    // data-move controller: push, wait for the rise, then load
    always @*
    begin
        dm_d = DM_IDLE;
        case (dm_q)
            DM_IDLE:
                dm_d = word_boundary ? DM_PUSH : DM_IDLE;  // see R15
            DM_PUSH:
                dm_d = rx_push_ready ? DM_WAIT : DM_PUSH;  // stalls while rx fifo is full
            DM_WAIT:
                dm_d = bclk_rise ? DM_LOAD : DM_WAIT;  // see R16
            DM_LOAD:
                dm_d = DM_IDLE;
            default:
                dm_d = DM_IDLE;
        endcase
    end

    assign rx_push_valid = (dm_q == DM_PUSH);
    assign tx_pop_ready  = (dm_q == DM_LOAD) & tx_pop_valid;

    // transmit shifter: shift on rises, reload one cycle after the rise
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            dm_q             <= DM_IDLE;
            tx_shift_value_q <= `TDM_TX_IDLE;
        end
        else
        begin
            dm_q <= dm_d;
            if (dm_q == DM_LOAD)
                tx_shift_value_q <= tx_pop_valid ? tx_pop_data : `TDM_TX_IDLE;  // see R14
            else if (bclk_rise)
                tx_shift_value_q <= {tx_shift_value_q[`TDM_WORD_W-2:0], 1'b0};  // see R2
        end
    end

    // group event held until the fourth word has been moved
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            group_pend_q       <= 1'b0;
            word_group_event_q <= 1'b0;
        end
        else
        begin
            word_group_event_q <= group_pend_q & (dm_q == DM_LOAD);  // see R14
            if (wc_event)
                group_pend_q <= 1'b1;  // see R6
            else if (dm_q == DM_LOAD)
                group_pend_q <= 1'b0;
        end
    end

    assign O_WORD_GROUP_EVENT = word_group_event_q;

    ////////////////////////////////////////////////////////////////////////////
    // cpu-side fifos
    tdm_fifo #(
        .WIDTH (`TDM_WORD_W),
        .DEPTH (`TDM_FIFO_DEPTH),
        .AW    (`TDM_FIFO_AW)
    ) u_rx_fifo (
        .i_clk      (I_CLK),
        .i_rst_n    (I_RST_N),
        .i_wr_data  (rx_word_q),
        .i_wr_valid (rx_push_valid),
        .o_wr_ready (rx_push_ready),
        .o_rd_data  (O_RX_DATA),
        .o_rd_valid (O_RX_VALID),
        .i_rd_ready (I_RX_READY)
    );

    tdm_fifo #(
        .WIDTH (`TDM_WORD_W),
        .DEPTH (`TDM_FIFO_DEPTH),
        .AW    (`TDM_FIFO_AW)
    ) u_tx_fifo (
        .i_clk      (I_CLK),
        .i_rst_n    (I_RST_N),
        .i_wr_data  (I_TX_DATA),
        .i_wr_valid (I_TX_VALID),
        .o_wr_ready (O_TX_READY),
        .o_rd_data  (tx_pop_data),
        .o_rd_valid (tx_pop_valid),
        .i_rd_ready (tx_pop_ready)
    );

endmodule // tdm_serial_port

// ---- tb/tdm_serial_port_assertions.sv ----
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// port-level checks of link timing, rx fifo and word-group events
module tdm_serial_port_checker (
    input logic        I_CLK,
    input logic        I_RST_N,
    input logic        I_BCLK,
    input logic        I_FSYNC,
    input logic        O_BCLK,
    input logic        O_FSYNC,
    input logic        O_DATA,
    input logic [31:0] O_RX_DATA,
    input logic        O_RX_VALID,
    input logic        I_RX_READY,
    input logic        O_WORD_GROUP_EVENT
);
    logic [9:0] since_evt_q;
    logic [4:0] since_fs_q;

    // saturating cycle counts since the last event and the last input sync
    always @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            since_evt_q <= 10'h3FF;
            since_fs_q  <= 5'h1F;
        end
        else
        begin
            since_evt_q <= O_WORD_GROUP_EVENT ? 10'h000 : since_evt_q + {9'h000, ~&since_evt_q};
            since_fs_q  <= I_FSYNC ? 5'h00 : since_fs_q + {4'h0, ~&since_fs_q};
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    // sync output pulse spans one bit period, then drops
    sequence fs_one_bit;
        O_FSYNC [*8];
    endsequence
    sequence fs_drop;
        !O_FSYNC;
    endsequence

    a_bclk_pass_through: assert property (O_BCLK == I_BCLK)
        else $error("bit clock output differs from input");
    a_data_on_rise: assert property ($changed(O_DATA) |-> $past(I_BCLK, 3) && !$past(I_BCLK, 7))
        else $error("data output moved away from a bit clock rise");
    a_fsync_on_rise: assert property ($changed(O_FSYNC) |-> $past(I_BCLK, 3) && !$past(I_BCLK, 7))
        else $error("sync output moved away from a bit clock rise");
    a_fsync_pulse_width: assert property ($rose(O_FSYNC) |-> fs_one_bit ##1 fs_drop)
        else $error("sync output pulse is not one bit wide");
    a_fsync_has_cause: assert property ($rose(O_FSYNC) |-> since_fs_q <= 5'h0C)
        else $error("sync output without a recent input sync");
    a_rx_push_after_fall: assert property ($rose(O_RX_VALID) |-> !$past(I_BCLK, 5) || !$past(I_BCLK, 6))
        else $error("receive word pushed away from a bit clock fall");
    a_rx_word_held: assert property (O_RX_VALID && !I_RX_READY |=> O_RX_VALID && $stable(O_RX_DATA))
        else $error("receive fifo head changed without a pop");
    a_event_spacing: assert property (O_WORD_GROUP_EVENT |-> since_evt_q >= 10'h2BC)
        else $error("word group events closer than four words");
endmodule // tdm_serial_port_checker

bind tdm_serial_port tdm_serial_port_checker u_tdm_serial_port_checker (
    .I_CLK, .I_RST_N, .I_BCLK, .I_FSYNC, .O_BCLK, .O_FSYNC, .O_DATA,
    .O_RX_DATA, .O_RX_VALID, .I_RX_READY, .O_WORD_GROUP_EVENT
);

// ---- tb/tdm_partner.sv ----
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// far-end tdm master: makes bit clock and sync, sends and captures words
module tdm_partner (
    input  logic i_clk,
    input  logic i_fsync,
    input  logic i_data,
    output logic o_bclk,
    output logic o_fsync,
    output logic o_data
);
    logic [31:0] sent[$];
    logic        cap_d[$];
    logic        cap_f[$];
    int          seq;

    // bit clock idles low between bursts
    initial
    begin
        o_bclk  = 1'b0;
        o_fsync = 1'b0;
        o_data  = 1'b0;
        seq     = 0;
    end

    // device output taken on each bit clock rise
    always @(posedge o_bclk)
    begin
        cap_d.push_back(i_data);
        cap_f.push_back(i_fsync);
    end

    // one bit: new level at the rise, sample point at the fall, 8 clocks long
    task automatic bit_out(input logic d, input logic s, input logic glitch);
        @(negedge i_clk);
        o_bclk  = 1'b1;
        o_data  = d;
        o_fsync = s | glitch;
        repeat (2) @(negedge i_clk);
        o_fsync = s; // a glitch sync is gone before the fall
        repeat (2) @(negedge i_clk);
        o_bclk = 1'b0;
        repeat (3) @(negedge i_clk); // long bit period keeps the reload after the rise
    endtask

    // whole frames of eight 32-bit words, msb first, sync on the first bit
    task automatic send(input int frames, input int glitch_word);
        logic [31:0] w;
        w = 32'h00000000;
        for (int f = 0; f < frames * 8; f++)
        begin
            w = 32'hA5C30F00 ^ (32'(seq) * 32'h01010101);
            seq++;
            sent.push_back(w);
            for (int b = 31; b >= 0; b--)
                bit_out(w[b], (f % 8 == 0) && (b == 31), (f == glitch_word) && (b == 16));
        end
        // trailing sync bit closes the last word and gives two more rises
        bit_out(~w[0], 1'b1, 1'b0);
        bit_out(1'b0, 1'b0, 1'b0);
        bit_out(1'b1, 1'b0, 1'b0);
        o_data = 1'b0; // released data line shows the inverse
    endtask
endmodule // tdm_partner

// ---- tb/tdm_serial_port_bench.sv ----
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// self-checking bench: link traffic both ways, fifo fill and drain
module tdm_serial_port_bench;
    logic        clk;
    logic        rst_n;
    logic        bclk;
    logic        fsync;
    logic        sdata;
    logic        bclk_out;
    logic        frame_sync_out;
    logic        sdata_out;
    logic [31:0] rx_data;
    logic        rx_valid;
    logic        rx_ready;
    logic [31:0] tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic        evt;
    int          errors;
    int          total_checks;
    int          evt_cnt;

    tdm_serial_port u_tdm_serial_port (
        .I_CLK(clk), .I_RST_N(rst_n), .I_BCLK(bclk), .I_FSYNC(fsync), .I_DATA(sdata),
        .O_BCLK(bclk_out), .O_FSYNC(frame_sync_out), .O_DATA(sdata_out),
        .O_RX_DATA(rx_data), .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready),
        .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready),
        .O_WORD_GROUP_EVENT(evt)
    );

    tdm_partner u_tdm_partner (
        .i_clk(clk), .i_fsync(frame_sync_out), .i_data(sdata_out),
        .o_bclk(bclk), .o_fsync(fsync), .o_data(sdata)
    );

    // 50 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // group event pulses counted as they come
    always @(posedge clk)
        if (evt === 1'b1) evt_cnt++;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [31:0] tx_pat(input int x);
        return 32'hC0000001 | (32'(x) * 32'h00111110);
    endfunction

    // push n words, ready expected while fewer than 32 are stored
    task automatic fill_tx(input int n, input int base, inout logic [31:0] q[$]);
        for (int i = 0; i < n; i++)
        begin
            check({31'h0, tx_ready}, {31'h0, q.size() < 32});
            if (q.size() < 32) q.push_back(tx_pat(base + i));
            tx_data  = tx_pat(base + i);
            tx_valid = 1'b1;
            @(negedge clk);
        end
        tx_valid = 1'b0;
    endtask

    // pop while the receive fifo offers words, bounded
    task automatic drain(inout logic [31:0] q[$]);
        for (int i = 0; i < 40 && rx_valid === 1'b1; i++)
        begin
            q.push_back(rx_data);
            rx_ready = 1'b1;
            @(negedge clk);
        end
        rx_ready = 1'b0;
    endtask

    // sent words must appear in order, after at most two leading stray words
    task automatic check_rx(input logic [31:0] got[$], input int n);
        int o;
        o = -1;
        for (int i = 2; i >= 0; i--)
            if (got.size() > i && got[i] === u_tdm_partner.sent[0]) o = i;
        check({31'h0, o >= 0}, 32'h1);
        for (int i = 0; i < n; i++)
            check(got[o + i], u_tdm_partner.sent[i]);
    endtask

    // words of the frame marked by the nth sync output: fifo order, then zeros
    task automatic check_tx(input int nth, input logic [31:0] txq[$]);
        int p;
        int n;
        int j;
        logic [31:0] w;
        p = -1;
        n = 0;
        j = -1;
        foreach (u_tdm_partner.cap_f[i])
            if (u_tdm_partner.cap_f[i] === 1'b1)
            begin
                n++;
                if (n == nth) p = i;
            end
        check({31'h0, p >= 0}, 32'h1);
        // a word's first bit trails the sync output by one bit: the load waits for the rise after the sync
        for (int k = 0; k < 8 && p >= 0; k++)
        begin
            w = 32'h00000000;
            for (int b = 0; b < 32; b++)
                w = {w[30:0], u_tdm_partner.cap_d[p + 1 + 32 * k + b]};
            if (j < 0 && w !== 32'h00000000)
            begin
                foreach (txq[i]) if (txq[i] === w) j = i;
                check({31'h0, j >= 0}, 32'h1);
            end
            else if (j >= 0)
            begin
                j++;
                check(w, (j < txq.size()) ? txq[j] : 32'h00000000);
            end
        end
    endtask

    // two frames with a sync glitch away from any fall, tx fifo runs dry
    task automatic scen_stream;
        logic [31:0] txq[$];
        logic [31:0] got[$];
        int nfs;
        fill_tx(12, 0, txq);
        u_tdm_partner.cap_d.delete();
        u_tdm_partner.cap_f.delete();
        evt_cnt = 0;
        u_tdm_partner.send(2, 3);
        repeat (40) @(negedge clk);
        drain(got);
        check_rx(got, 16);
        check_tx(2, txq);
        check(32'(evt_cnt), 32'h4);
        nfs = 0;
        foreach (u_tdm_partner.cap_f[i]) if (u_tdm_partner.cap_f[i] === 1'b1) nfs++;
        check(32'(nfs), 32'h3);
        check({31'h0, bclk_out}, {31'h0, bclk});
    endtask

    // tx fifo filled until refused, rx fifo left full, then both drained
    task automatic scen_buffers;
        logic [31:0] txq[$];
        logic [31:0] got[$];
        fill_tx(33, 100, txq);
        u_tdm_partner.cap_d.delete();
        u_tdm_partner.cap_f.delete();
        u_tdm_partner.sent.delete();
        u_tdm_partner.send(4, -1);
        repeat (40) @(negedge clk);
        check({31'h0, rx_valid}, 32'h1);
        drain(got);
        check(32'(got.size()), 32'h21);
        check({31'h0, rx_valid}, 32'h0);
        check_rx(got, 30);
        check_tx(2, txq);
        check({31'h0, tx_ready}, 32'h1);
    endtask

    // reset, scenarios, verdict
    initial
    begin
        errors       = 0;
        total_checks = 0;
        evt_cnt      = 0;
        rst_n        = 1'b0;
        rx_ready     = 1'b0;
        tx_data      = 32'h00000000;
        tx_valid     = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        scen_stream();
        scen_buffers();
        report_and_stop();
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule // tdm_serial_port_bench
